// ---- inc/dlsi_pkg.sv ----
// Purpose: Shared constants and types for the data link / SSM irq block
// Assumes: AHB-Lite word access, one clock, sync active-high reset
// Notes: Register index times four gives the byte address
package dlsi_pkg;

    // ==========================================================
    // Register indices
    localparam logic [11:0] DL_STAT_IDX = 12'h0b26;
    localparam logic [11:0] DL_EN_IDX = 12'h0b27;
    localparam logic [11:0] SSM_STAT_IDX = 12'h0b70;
    localparam logic [11:0] SSM_EN_IDX = 12'h0b71;
    localparam logic [11:0] UNS_STAT_IDX = 12'h0b74;
    localparam logic [11:0] UNS_EN_IDX = 12'h0b75;
    localparam logic [11:0] CLR_IDX = 12'h0b7e;

    // ==========================================================
    // Field positions
    localparam int DL_TX_BEGIN_BIT = 6;
    localparam int DL_RX_BEGIN_BIT = 5;
    localparam int DL_TX_END_BIT = 4;
    localparam int DL_RX_END_BIT = 3;
    localparam int DL_FCS_BIT = 2;
    localparam int DL_ABORT_BIT = 1;
    localparam int DL_IDLE_BIT = 0;
    localparam int SSM_MATCH3_BIT = 7;
    localparam int SSM_MATCH2_BIT = 6;
    localparam int SSM_FULL_BIT = 3;
    localparam int SSM_EMPTY_BIT = 2;
    localparam int SSM_MATCH1_BIT = 1;
    localparam int SSM_CHANGE_BIT = 0;
    localparam int UNS_BIT = 6;
    localparam int CLR_DL_LSB = 0;
    localparam int CLR_SSM_LSB = 8;
    localparam int CLR_UNS_LSB = 16;

    // ==========================================================
    // Implemented-bit masks and reset values
    localparam logic [7:0] DL_MASK = 8'h7f;
    localparam logic [7:0] SSM_MASK = 8'hcf;
    localparam logic [7:0] UNS_MASK = 8'h40;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    // ==========================================================
    // Register select codes
    localparam logic [2:0] SEL_NONE = 3'h0;
    localparam logic [2:0] SEL_DL_STAT = 3'h1;
    localparam logic [2:0] SEL_DL_EN = 3'h2;
    localparam logic [2:0] SEL_SSM_STAT = 3'h3;
    localparam logic [2:0] SEL_SSM_EN = 3'h4;
    localparam logic [2:0] SEL_UNS_STAT = 3'h5;
    localparam logic [2:0] SEL_UNS_EN = 3'h6;
    localparam logic [2:0] SEL_CLR = 3'h7;

    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_WAIT = 3'b010,
        BUS_DONE = 3'b100
    } dlsi_bus_st_t;

    typedef struct packed {
        logic tx_msg_begin_flag;
        logic rx_msg_begin_flag;
        logic tx_msg_end_flag;
        logic rx_msg_end_flag;
        logic rx_buf_full;
        logic fcs_err;
        logic abort_seen;
        logic rx_idle_flag;
        logic msg_type;
    } dlsi_dl_evt_t;

    typedef struct packed {
        logic ssm_match_third;
        logic ssm_match_second;
        logic ssm_match_first;
        logic tx_ssm_empty_flag;
        logic rx_code_change_flag;
        logic ssm_valid;
        logic [7:0] rx_ssm_holding;
    } dlsi_ssm_evt_t;

    typedef struct packed {
        dlsi_bus_st_t bus;
        logic [2:0] sel;
        logic wr;
        logic [31:0] rdata;
        logic [7:0] dl_stat;
        logic [7:0] dl_en;
        logic [7:0] ssm_stat;
        logic [7:0] ssm_en;
        logic [7:0] uns_stat;
        logic [7:0] uns_en;
        logic [7:0] ssm_prev;
        logic ssm_seen;
        logic irq;
    } dlsi_state_t;

endpackage : dlsi_pkg

// ---- logic/dlsi_top.sv ----
// Purpose: Interrupt status/enable registers, data link 3 and SSM unit
// Assumes: Event inputs are one-cycle pulses on clock; AHB-Lite slave
// Notes: Status bits except data link bit 7 (live msg_type) are sticky, cleared by read or by clear register
//
// Function
// - Set rx end status bit 3 on message end or receive buffer full.
// - Set FCS error status bit 2 on frame check mismatch.
// - Set abort status bit 1 on seven consecutive ones.
// - Set idle status bit 0 on flag octet detection.
// - Reading data link status clears its sticky bits.
// - Enable bit 6 gates transmit message begin interrupt.
// - Enable bit 5 gates receive message begin interrupt.
// - Enable bit 4 gates transmit message end interrupt.
// - Enable bit 3 gates receive message end interrupt.
// - Set SSM match bits 7, 6, 1 on validated match.
// - Set SSM full bit 3 on every valid code, unfiltered.
// - Set SSM empty bit 2 when repetitions finished.
// - Set change bit 0 on filtered SSM change.
// - SSM enable bits gate events; bits 5 to 4 reserved zero.
// - Set unstable bit 6 when valid SSM differs from previous.
// - Reading unstable status clears it.
// - Unstable enable bit 6 gates unstable interrupt; rest reserved.
//
// Local design decision: the AHB-Lite slave port.

`timescale 1ns/1ps
`default_nettype none

module dlsi_top
    import dlsi_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Event sources
    input wire dlsi_dl_evt_t dl_evt,
    input wire dlsi_ssm_evt_t ssm_evt,
    // Interrupt
    output logic irq
);

    // ==========================================================
    // Functions
    // Registers sit one per word: byte address is index times four
    function automatic logic [31:0] dlsi_word_addr(
        input logic [11:0] idx
    );
        return 32'(idx) << 2;
    endfunction : dlsi_word_addr

    function automatic logic [2:0] dlsi_decode(
        input logic [31:0] addr
    );
        logic [2:0] sel;
        sel = SEL_NONE;
        if (addr == dlsi_word_addr(DL_STAT_IDX))
        begin
            sel = SEL_DL_STAT;
        end
        else if (addr == dlsi_word_addr(DL_EN_IDX))
        begin
            sel = SEL_DL_EN;
        end
        else if (addr == dlsi_word_addr(SSM_STAT_IDX))
        begin
            sel = SEL_SSM_STAT;
        end
        else if (addr == dlsi_word_addr(SSM_EN_IDX))
        begin
            sel = SEL_SSM_EN;
        end
        else if (addr == dlsi_word_addr(UNS_STAT_IDX))
        begin
            sel = SEL_UNS_STAT;
        end
        else if (addr == dlsi_word_addr(UNS_EN_IDX))
        begin
            sel = SEL_UNS_EN;
        end
        else if (addr == dlsi_word_addr(CLR_IDX))
        begin
            sel = SEL_CLR;
        end
        return sel;
    endfunction : dlsi_decode

    // Set wins over clear so an event in the clearing cycle survives
    function automatic logic [7:0] dlsi_sticky(
        input logic [7:0] old,
        input logic [7:0] set,
        input logic [7:0] clr,
        input logic [7:0] mask
    );
        return ((old & ~clr) | set) & mask;
    endfunction : dlsi_sticky

    // ==========================================================
    // State
    dlsi_state_t st_ff;
    dlsi_state_t nxt_st;
    logic take;
    logic data_phase;
    logic rd_now;
    logic wr_now;
    logic [7:0] dl_set;
    logic [7:0] ssm_set;
    logic [7:0] uns_set;
    logic [7:0] dl_clr;
    logic [7:0] ssm_clr;
    logic [7:0] uns_clr;
    logic [7:0] dl_view;
    logic [31:0] rd_mux;
    logic rd_dl_stat;
    logic rd_ssm_stat;
    logic rd_uns_stat;
    logic wr_dl_en;
    logic wr_ssm_en;
    logic wr_uns_en;
    logic wr_clr;
    logic ssm_differs;
    logic [7:0] dl_pend;
    logic [7:0] ssm_pend;
    logic [7:0] uns_pend;
    logic any_pend;

    assign take = hsel && htrans[1] && hready;
    assign data_phase = (st_ff.bus == BUS_WAIT);
    assign rd_now = data_phase && !st_ff.wr;
    assign wr_now = data_phase && st_ff.wr;
    assign dl_view = {dl_evt.msg_type, st_ff.dl_stat[6:0]};
    // a first valid value has nothing to compare with
    assign ssm_differs = st_ff.ssm_seen
        && (ssm_evt.rx_ssm_holding != st_ff.ssm_prev);

    // ==========================================================
    // Register strobes, valid only in the data phase
    always_comb
    begin
        rd_dl_stat = rd_now && (st_ff.sel == SEL_DL_STAT);
        rd_ssm_stat = rd_now && (st_ff.sel == SEL_SSM_STAT);
        rd_uns_stat = rd_now && (st_ff.sel == SEL_UNS_STAT);
        wr_dl_en = wr_now && (st_ff.sel == SEL_DL_EN);
        wr_ssm_en = wr_now && (st_ff.sel == SEL_SSM_EN);
        wr_uns_en = wr_now && (st_ff.sel == SEL_UNS_EN);
        wr_clr = wr_now && (st_ff.sel == SEL_CLR);
    end

    // ==========================================================
    // Pending sources: a status bit counts only while enabled
    always_comb
    begin
        // data link enables gate their events
        dl_pend = st_ff.dl_stat & st_ff.dl_en;
        ssm_pend = st_ff.ssm_stat & st_ff.ssm_en;
        uns_pend = st_ff.uns_stat & st_ff.uns_en;
        any_pend = (|dl_pend) || (|ssm_pend) || (|uns_pend);
    end

    // ==========================================================
    // Event capture
    always_comb
    begin
        dl_set = REG_RESET;
        dl_set[DL_TX_BEGIN_BIT] = dl_evt.tx_msg_begin_flag;
        dl_set[DL_RX_BEGIN_BIT] = dl_evt.rx_msg_begin_flag;
        dl_set[DL_TX_END_BIT] = dl_evt.tx_msg_end_flag;
        dl_set[DL_RX_END_BIT] = dl_evt.rx_msg_end_flag
            | dl_evt.rx_buf_full;
        dl_set[DL_FCS_BIT] = dl_evt.fcs_err;
        dl_set[DL_ABORT_BIT] = dl_evt.abort_seen;
        dl_set[DL_IDLE_BIT] = dl_evt.rx_idle_flag;

        ssm_set = REG_RESET;
        ssm_set[SSM_MATCH3_BIT] = ssm_evt.ssm_match_third;
        ssm_set[SSM_MATCH2_BIT] = ssm_evt.ssm_match_second;
        ssm_set[SSM_MATCH1_BIT] = ssm_evt.ssm_match_first;
        ssm_set[SSM_FULL_BIT] = ssm_evt.ssm_valid;
        ssm_set[SSM_EMPTY_BIT] = ssm_evt.tx_ssm_empty_flag;
        ssm_set[SSM_CHANGE_BIT] = ssm_evt.rx_code_change_flag;

        uns_set = REG_RESET;
        uns_set[UNS_BIT] = ssm_evt.ssm_valid && ssm_differs;
    end

    // ==========================================================
    // Clear sources: read of a status word or write of the clear word
    always_comb
    begin
        dl_clr = REG_RESET;
        ssm_clr = REG_RESET;
        uns_clr = REG_RESET;
        if (rd_dl_stat)
        begin
            dl_clr = DL_MASK;
        end
        if (rd_ssm_stat)
        begin
            ssm_clr = SSM_MASK;
        end
        if (rd_uns_stat)
        begin
            uns_clr = UNS_MASK;
        end
        if (wr_clr)
        begin
            dl_clr = dl_clr | hwdata[CLR_DL_LSB +: 8];
            ssm_clr = ssm_clr | hwdata[CLR_SSM_LSB +: 8];
            uns_clr = uns_clr | hwdata[CLR_UNS_LSB +: 8];
        end
    end

    // ==========================================================
    // Read mux; reserved bits and unmapped words read as zero
    always_comb
    begin
        rd_mux = RDATA_RESET;
        case (st_ff.sel)
            SEL_DL_STAT: rd_mux[7:0] = dl_view;
            SEL_DL_EN: rd_mux[7:0] = st_ff.dl_en;
            SEL_SSM_STAT: rd_mux[7:0] = st_ff.ssm_stat;
            SEL_SSM_EN: rd_mux[7:0] = st_ff.ssm_en;
            SEL_UNS_STAT: rd_mux[7:0] = st_ff.uns_stat;
            SEL_UNS_EN: rd_mux[7:0] = st_ff.uns_en;
            // Clear word is write-only
            SEL_CLR: rd_mux = RDATA_RESET;
            default: rd_mux = RDATA_RESET;
        endcase
    end

    // ==========================================================
    // Next state
    always_comb
    begin
        nxt_st = st_ff;

        // Bus sequencing: one wait state per transfer so read data
        // can come from a flop
        case (st_ff.bus)
            BUS_IDLE:
            begin
                if (take)
                begin
                    nxt_st.bus = BUS_WAIT;
                    nxt_st.sel = dlsi_decode(haddr);
                    nxt_st.wr = hwrite;
                end
            end
            BUS_WAIT:
            begin
                nxt_st.bus = BUS_DONE;
                if (!st_ff.wr)
                begin
                    nxt_st.rdata = rd_mux;
                end
            end
            BUS_DONE:
            begin
                if (take)
                begin
                    nxt_st.bus = BUS_WAIT;
                    nxt_st.sel = dlsi_decode(haddr);
                    nxt_st.wr = hwrite;
                end
                else
                begin
                    nxt_st.bus = BUS_IDLE;
                end
            end
            default:
            begin
                nxt_st.bus = BUS_IDLE;
            end
        endcase

        // Enable writes
        if (wr_dl_en)
        begin
            nxt_st.dl_en = hwdata[7:0] & DL_MASK;
        end
        if (wr_ssm_en)
        begin
            nxt_st.ssm_en = hwdata[7:0] & SSM_MASK;
        end
        if (wr_uns_en)
        begin
            nxt_st.uns_en = hwdata[7:0] & UNS_MASK;
        end

        // Sticky status
        nxt_st.dl_stat = dlsi_sticky(st_ff.dl_stat, dl_set, dl_clr,
            DL_MASK);
        nxt_st.ssm_stat = dlsi_sticky(st_ff.ssm_stat, ssm_set,
            ssm_clr, SSM_MASK);
        nxt_st.uns_stat = dlsi_sticky(st_ff.uns_stat, uns_set,
            uns_clr, UNS_MASK);

        if (ssm_evt.ssm_valid)
        begin
            nxt_st.ssm_prev = ssm_evt.rx_ssm_holding;
            nxt_st.ssm_seen = 1'b1;
        end

        // registered so the request line never glitches
        nxt_st.irq = any_pend;

        if (rst)
        begin
            nxt_st.bus = BUS_IDLE;
            nxt_st.sel = SEL_NONE;
            nxt_st.wr = 1'b0;
            nxt_st.rdata = RDATA_RESET;
            nxt_st.dl_stat = REG_RESET;
            nxt_st.dl_en = REG_RESET;
            nxt_st.ssm_stat = REG_RESET;
            nxt_st.ssm_en = REG_RESET;
            nxt_st.uns_stat = REG_RESET;
            nxt_st.uns_en = REG_RESET;
            nxt_st.ssm_prev = REG_RESET;
            nxt_st.ssm_seen = 1'b0;
            nxt_st.irq = 1'b0;
        end
    end

    // ==========================================================
    // Registers
    // Reset lives in the next-state logic, keeping one clocked process
    always_ff @(posedge clock)
    begin
        st_ff <= nxt_st;
    end

    // ==========================================================
    // Outputs
    // Low only in the data phase: one wait state, no more
    assign hreadyout = (st_ff.bus != BUS_WAIT);
    // Only OKAY is ever answered
    assign hresp = 1'b0;
    assign hrdata = st_ff.rdata;
    assign irq = st_ff.irq;

endmodule : dlsi_top

`default_nettype wire

// ---- test/dlsi_top_sva.sv ----
// Purpose: Port-level assertions for the data link / SSM irq block
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to every dlsi_top instance below
`timescale 1ns/1ps
`default_nettype none

module dlsi_top_sva
    import dlsi_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // Events and interrupt
    input wire dlsi_dl_evt_t dl_evt,
    input wire dlsi_ssm_evt_t ssm_evt,
    input wire logic irq
);
    logic take;
    logic rd;
    logic uns_rd;
    logic ev;
    assign take = hsel && htrans[1] && hready;
    assign rd = take && !hwrite;
    assign uns_rd = rd && haddr == {18'h0_0000, UNS_STAT_IDX, 2'b00};
    // msg_type is a level, not an event
    assign ev = (|dl_evt[8:1]) || (|ssm_evt[13:8]);

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    // ==========================================================
    // Bus
    property p_okay;
        !hresp;
    endproperty
    a_okay: assert property (p_okay) else $error("hresp not OKAY");
    property p_wait;
        take |=> !hreadyout ##1 hreadyout;
    endproperty
    a_wait: assert property (p_wait) else $error("wait state wrong");
    property p_rst;
        $fell(rst) |-> hreadyout && !irq && hrdata == 32'h0000_0000;
    endproperty
    a_rst: assert property (p_rst) else $error("bad state after reset");
    property p_rdata;
        !$stable(hrdata) |-> !$past(hreadyout);
    endproperty
    a_rdata: assert property (p_rdata) else $error("hrdata moved");
    property p_upper;
        rd |-> ##2 hrdata[31:8] == 24'h00_0000;
    endproperty
    a_upper: assert property (p_upper) else $error("upper bits set");
    property p_uns;
        uns_rd |-> ##2 hrdata[7:0] == (hrdata[7:0] & UNS_MASK);
    endproperty
    a_uns: assert property (p_uns) else $error("reserved set");

    // ==========================================================
    // Interrupt
    property p_rise;
        $rose(irq) |-> $past(ev, 2) || !$past(hreadyout, 2);
    endproperty
    a_rise: assert property (p_rise) else $error("irq without cause");
    property p_fall;
        $fell(irq) |-> !$past(hreadyout, 2);
    endproperty
    a_fall: assert property (p_fall) else $error("irq fell alone");

    c_irq: cover property ($rose(irq));
    c_uns: cover property (uns_rd ##2 hrdata[6]);
    c_rd: cover property (rd ##2 hrdata[0]);
endmodule : dlsi_top_sva

bind dlsi_top dlsi_top_sva u_sva (.*);

`default_nettype wire

// ---- test/dlsi_top_tb.sv ----
// Purpose: Self-checking bench for the data link / SSM irq block
// Assumes: One wait state per transfer, one-cycle event pulses
// Notes: Bench drives bus and event sources itself
`timescale 1ns/1ps
`default_nettype none

module dlsi_top_tb
    import dlsi_pkg::*;
;
    logic clock;
    logic rst;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [31:0] hwdata;
    logic hreadyout;
    logic [31:0] hrdata;
    logic irq;
    dlsi_dl_evt_t dl_evt;
    dlsi_ssm_evt_t ssm_evt;
    int err_count;
    int checks_done;
    logic [31:0] rv;

    // Slave ready looped back as bus ready
    dlsi_top DUT (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(),
        .hrdata(hrdata), .dl_evt(dl_evt), .ssm_evt(ssm_evt), .irq(irq));

    // ==========================================================
    // Shared tasks
    task automatic stop_test;
        $display("Mismatches %0d, checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wait_rdy;
        for (int n = 0; n < 16; n++)
        begin
            @(posedge clock);
            if (hreadyout === 1'b1)
                return;
        end
        err_count++;
        stop_test();
    endtask : wait_rdy

    task automatic bus(input logic w, input logic [11:0] idx,
                       input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {18'h0_0000, idx, 2'b00};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        rv = hrdata;
    endtask : bus

    task automatic rd_chk(input logic [11:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0000_0000);
        chk(rv, exp);
    endtask : rd_chk

    task automatic irq_is(input logic e);
        @(posedge clock);
        #1;
        chk(32'(irq), 32'(e));
    endtask : irq_is

    // Pulse events for one cycle, then look at irq
    task automatic ev(input dlsi_dl_evt_t d, input dlsi_ssm_evt_t s,
                      input logic e);
        @(posedge clock);
        dl_evt <= d;
        ssm_evt <= s;
        @(posedge clock);
        dl_evt <= '0;
        ssm_evt <= '0;
        irq_is(e);
    endtask : ev

    // ==========================================================
    // Scenarios
    task automatic t_reset;
        logic [11:0] idx[8] = '{DL_STAT_IDX, DL_EN_IDX, SSM_STAT_IDX,
            SSM_EN_IDX, UNS_STAT_IDX, UNS_EN_IDX, CLR_IDX, 12'h0000};
        bus(1'b1, 12'h0000, 32'h0000_00ff);
        foreach (idx[i])
            rd_chk(idx[i], 32'h0000_0000);
        irq_is(1'b0);
    endtask : t_reset

    task automatic t_uns;
        bus(1'b1, UNS_EN_IDX, 32'h0000_00ff);
        rd_chk(UNS_EN_IDX, 32'h0000_0040);
        ev('0, 14'h0111, 1'b0);
        ev('0, 14'h0111, 1'b0);
        ev('0, 14'h0122, 1'b1);
        rd_chk(UNS_STAT_IDX, 32'h0000_0040);
        rd_chk(UNS_STAT_IDX, 32'h0000_0000);
        irq_is(1'b0);
        bus(1'b1, UNS_EN_IDX, 32'h0000_0000);
        ev('0, 14'h0133, 1'b0);
        rd_chk(UNS_STAT_IDX, 32'h0000_0040);
        rd_chk(SSM_STAT_IDX, 32'h0000_0008);
    endtask : t_uns

    task automatic t_dl;
        int map[8] = '{0, 1, 2, 3, 3, 4, 5, 6};
        bus(1'b1, DL_EN_IDX, 32'h0000_00ff);
        rd_chk(DL_EN_IDX, 32'h0000_007f);
        for (int i = 0; i < 8; i++)
        begin
            bus(1'b1, DL_EN_IDX, 32'(1) << map[i]);
            // Event two places on is masked, own event fires
            ev(9'(2) << ((i + 2) % 8), '0, 1'b0);
            ev(9'(2) << i, '0, 1'b1);
            rd_chk(DL_STAT_IDX, (32'(1) << map[i]) |
                (32'(1) << map[(i + 2) % 8]));
            rd_chk(DL_STAT_IDX, 32'h0000_0000);
            irq_is(1'b0);
        end
        ev(9'h022, '0, 1'b0);
        rd_chk(DL_STAT_IDX, 32'h0000_0009);
        ev(9'h002, '0, 1'b0);
        bus(1'b1, CLR_IDX, 32'h0000_0001);
        rd_chk(DL_STAT_IDX, 32'h0000_0000);
    endtask : t_dl

    task automatic t_ssm;
        int map[6] = '{3, 0, 2, 1, 6, 7};
        bus(1'b1, SSM_EN_IDX, 32'h0000_00ff);
        rd_chk(SSM_EN_IDX, 32'h0000_00cf);
        for (int i = 0; i < 6; i++)
        begin
            ev('0, 14'h0100 << i, 1'b1);
            rd_chk(SSM_STAT_IDX, 32'(1) << map[i]);
            rd_chk(SSM_STAT_IDX, 32'h0000_0000);
            irq_is(1'b0);
        end
    endtask : t_ssm

    // Reset in mid-run drops status, enables and the interrupt
    task automatic t_mid_rst;
        bus(1'b1, DL_EN_IDX, 32'h0000_0001);
        ev(9'h002, '0, 1'b1);
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        irq_is(1'b0);
        rd_chk(DL_EN_IDX, 32'h0000_0000);
        rd_chk(DL_STAT_IDX, 32'h0000_0000);
    endtask : t_mid_rst

    // ==========================================================
    // Clock and main sequence
    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    initial
    begin
        err_count = 0;
        checks_done = 0;
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0000_0000;
        dl_evt = '0;
        ssm_evt = '0;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_uns();
        t_dl();
        t_ssm();
        t_mid_rst();
        stop_test();
    end
endmodule : dlsi_top_tb

`default_nettype wire
